/* File: rtl/auto_reload_timer_regs.sv */
// auto-reload timer: apb register file, prescaler, counter, compare, capture and pulse output
// Notes on behaviour
// - writing one to load trigger loads reload value, clears prescaler; reads zero
// - count enable clear stops counting in counter and prescaler; loads and capture clears still act; set lets counter advance
// - pulse output pin shows waveform only while pulse output enable is set
// - edge interrupt request is edge flag and edge interrupt enable
// - match interrupt request is match flag and match interrupt enable
// - rollover interrupt request is rollover flag and rollover interrupt enable
// - mode: auto-reload, capture, capture with clear, load on input edge
// - reset clears whole mode control register, timer disabled
// - writing zero clears a flag; writing one leaves it unchanged
// - edge flag sets on every active edge of timer input pin
// - match flag sets when counter equals compare value
// - rollover flag sets when counter passes from maximum and reloads from reload/capture register
// - prescale ratio two to the field; changing field keeps prescaler count
// - edge detect enable turns detection on; polarity: clear rising, set falling
// - clock select: internal, internal divided by three, input pin, reserved
// - live load register reads and writes counter on the fly; reset clears it to zero
// - on overflow counter reloads from reload/capture register
// - compare register holds value compared with counter on each prescaled count
// - live load write puts value in counter at once, running or not
// - overflow drives pulse high; compare match drives it low
// - capture modes copy counter into reload/capture register on active edge
// - external load mode copies reload value into counter on active edge unless a software load lands in the same cycle
//
// The APB register port was left to the implementer.
module auto_reload_timer_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  output logic pulse_output_pin,
  output ar_timer_pkg::irq_type irq_request
);

  typedef struct packed {
    ar_timer_pkg::mode_control_type mode_control;
    ar_timer_pkg::clock_edge_config_type config_reg;
    ar_timer_pkg::event_flags_type flags;
    logic [7:0] reload_capture_value;
    logic [7:0] compare_value;
    logic [6:0] prescaler_count;
    logic [7:0] main_counter;
    logic [1:0] div3_count;
    logic input_prev;
    logic pulse_level;
    logic [31:0] read_data;
  } state_type;

  state_type state;
  state_type next_state;
  logic [7:0] live_counter_load;

  logic access;
  logic write_hit;
  logic [7:0] word_index;
  logic addr_ok;
  logic [7:0] wbyte;
  logic active_edge;
  logic source_tick;
  logic prescale_tick;
  logic load_write;
  logic trigger_load;
  logic [7:0] read_byte;
  logic [6:0] low_bits_set;

  assign access = psel && penable;
  assign word_index = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                   (word_index == ar_timer_pkg::idx_timer_mode_control ||
                    word_index == ar_timer_pkg::idx_timer_event_flags ||
                    word_index == ar_timer_pkg::idx_timer_clock_edge_config ||
                    word_index == ar_timer_pkg::idx_reload_capture_value ||
                    word_index == ar_timer_pkg::idx_compare_value ||
                    word_index == ar_timer_pkg::idx_live_counter_load);
  // writes land only with the low byte lane enabled; narrower data lives in bits 7:0
  assign write_hit = access && pwrite && addr_ok && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;
  assign prdata = state.read_data;

  assign load_write = write_hit && (word_index == ar_timer_pkg::idx_live_counter_load);
  assign trigger_load = write_hit && (word_index == ar_timer_pkg::idx_timer_mode_control) &&
                        wbyte[ar_timer_pkg::load_trigger_bit];

  // pin treated as synchronous; edge seen against previous sample
  always_comb begin
    active_edge = 1'b0;
    if (state.config_reg.edge_detect_enable) begin
      if (state.config_reg.edge_polarity) begin
        active_edge = state.input_prev && !timer_input_pin;
      end else begin
        active_edge = !state.input_prev && timer_input_pin;
      end
    end
  end

  always_comb begin
    case (state.config_reg.clock_sel)
      ar_timer_pkg::clock_internal: source_tick = 1'b1;
      ar_timer_pkg::clock_internal_div3: source_tick = (state.div3_count == ar_timer_pkg::div3_last);
      ar_timer_pkg::clock_input_pin: source_tick = !state.input_prev && timer_input_pin;
      ar_timer_pkg::clock_reserved: source_tick = 1'b0;
      default: source_tick = 1'b0;
    endcase
  end

  // divide by 2^sel: tick when low sel bits of prescaler are all ones
  for (genvar g = 0; g < 7; g++) begin : gen_prescale_mask
    assign low_bits_set[g] = (g >= int'(state.config_reg.prescale_sel)) || state.prescaler_count[g];
  end

  always_comb begin
    prescale_tick = (&low_bits_set) && source_tick && state.mode_control.count_enable;
  end

  always_comb begin
    case (word_index)
      ar_timer_pkg::idx_timer_mode_control: read_byte = {1'b0, state.mode_control};
      ar_timer_pkg::idx_timer_event_flags: read_byte = {5'h00, state.flags};
      ar_timer_pkg::idx_timer_clock_edge_config: read_byte = state.config_reg;
      ar_timer_pkg::idx_reload_capture_value: read_byte = state.reload_capture_value;
      ar_timer_pkg::idx_compare_value: read_byte = state.compare_value;
      ar_timer_pkg::idx_live_counter_load: read_byte = state.main_counter;
      default: read_byte = 8'h00;
    endcase
  end

  always_comb begin
    logic overflow;
    logic match;
    logic capture;
    logic [7:0] counter_now;
    next_state = state;
    overflow = 1'b0;
    match = 1'b0;
    capture = (state.mode_control.mode == ar_timer_pkg::mode_capture ||
               state.mode_control.mode == ar_timer_pkg::mode_capture_clear) && active_edge;
    counter_now = state.main_counter;
    next_state.input_prev = timer_input_pin;
    // captured in the setup cycle so the word stands through the zero-wait access phase
    if (psel && !penable && !pwrite && addr_ok) begin
      next_state.read_data = {24'h00_0000, read_byte};
    end else if (access) begin
      next_state.read_data = state.read_data;
    end else begin
      next_state.read_data = 32'h0000_0000;
    end
    // divide-by-three runs free so the selected rate is steady
    if (state.div3_count == ar_timer_pkg::div3_last) begin
      next_state.div3_count = 2'h0;
    end else begin
      next_state.div3_count = state.div3_count + 2'h1;
    end

    if (prescale_tick) begin
      next_state.prescaler_count = 7'h00;
      if (state.main_counter == ar_timer_pkg::counter_max) begin
        overflow = 1'b1;
        next_state.main_counter = state.reload_capture_value;
      end else begin
        next_state.main_counter = state.main_counter + 8'h01;
      end
    end else if (source_tick && state.mode_control.count_enable) begin
      next_state.prescaler_count = state.prescaler_count + 7'h01;
    end
    if (prescale_tick) begin
      match = (next_state.main_counter == state.compare_value);
    end

    if (capture) begin
      next_state.reload_capture_value = counter_now;
      if (state.mode_control.mode == ar_timer_pkg::mode_capture_clear) begin
        next_state.main_counter = 8'h00;
        next_state.prescaler_count = 7'h00;
      end
    end
    if (state.mode_control.mode == ar_timer_pkg::mode_external_load && active_edge) begin
      next_state.main_counter = state.reload_capture_value;
      next_state.prescaler_count = 7'h00;
    end

    if (overflow) begin
      next_state.pulse_level = 1'b1;
    end else if (match) begin
      next_state.pulse_level = 1'b0;
    end

    if (write_hit) begin
      case (word_index)
        ar_timer_pkg::idx_timer_mode_control: next_state.mode_control = wbyte[6:0];
        ar_timer_pkg::idx_timer_clock_edge_config: next_state.config_reg = wbyte;
        ar_timer_pkg::idx_reload_capture_value: next_state.reload_capture_value = wbyte;
        ar_timer_pkg::idx_compare_value: next_state.compare_value = wbyte;
        ar_timer_pkg::idx_timer_event_flags: begin
          next_state.flags = state.flags & wbyte[2:0];
        end
        default: next_state.mode_control = next_state.mode_control;
      endcase
    end
    // software loads win over counting in the same cycle
    if (trigger_load) begin
      next_state.main_counter = (write_hit && word_index == ar_timer_pkg::idx_reload_capture_value) ?
                                wbyte : state.reload_capture_value;
      next_state.prescaler_count = 7'h00;
    end
    if (load_write) begin
      next_state.main_counter = wbyte;
      next_state.prescaler_count = 7'h00;
    end

    // hardware set beats software clear in the same cycle
    if (active_edge) begin
      next_state.flags.edge_flag = 1'b1;
    end
    if (match) begin
      next_state.flags.match_flag = 1'b1;
    end
    if (overflow) begin
      next_state.flags.rollover_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.mode_control <= ar_timer_pkg::mode_control_reset[6:0];
      state.config_reg <= ar_timer_pkg::config_reset;
      state.flags <= ar_timer_pkg::flags_reset[2:0];
      state.reload_capture_value <= ar_timer_pkg::data_reset;
      state.compare_value <= ar_timer_pkg::data_reset;
      state.prescaler_count <= 7'h00;
      state.main_counter <= ar_timer_pkg::data_reset;
      state.div3_count <= 2'h0;
      state.input_prev <= 1'b0;
      state.pulse_level <= 1'b0;
      state.read_data <= 32'h0000_0000;
    end else begin
      state <= next_state;
    end
  end

  // live load is a window onto the counter: no storage of its own, so reset clears it with the counter
  assign live_counter_load = state.main_counter;

  assign pulse_output_pin = state.pulse_level && state.mode_control.pulse_output_enable;
  assign irq_request.edge_irq = state.flags.edge_flag && state.mode_control.edge_irq_enable;
  assign irq_request.match_irq = state.flags.match_flag && state.mode_control.match_irq_enable;
  assign irq_request.rollover_irq = state.flags.rollover_flag &&
                                    state.mode_control.rollover_irq_enable;

endmodule // auto_reload_timer_regs

/* File: pkg/ar_timer_pkg.sv */
// package: register map, field positions, reset values and types of the auto-reload timer
package ar_timer_pkg;
  // printed offsets are not multiples of four: they are word indexes, byte address = 4 * index
  localparam logic [7:0] idx_timer_mode_control = 8'hD5;
  localparam logic [7:0] idx_timer_event_flags = 8'hD6;
  localparam logic [7:0] idx_timer_clock_edge_config = 8'hD7;
  localparam logic [7:0] idx_reload_capture_value = 8'hD9;
  localparam logic [7:0] idx_compare_value = 8'hDA;
  localparam logic [7:0] idx_live_counter_load = 8'hDB;

  // timer_mode_control fields
  localparam int load_trigger_bit = 7;
  localparam int count_enable_bit = 6;
  localparam int pulse_output_enable_bit = 5;
  localparam int edge_irq_enable_bit = 4;
  localparam int match_irq_enable_bit = 3;
  localparam int rollover_irq_enable_bit = 2;
  // timer_event_flags fields
  localparam int edge_flag_bit = 2;
  localparam int match_flag_bit = 1;
  localparam int rollover_flag_bit = 0;
  // timer_clock_edge_config fields
  localparam int prescale_sel_lsb = 5;
  localparam int reserved_cfg_bit = 4;
  localparam int edge_polarity_bit = 3;
  localparam int edge_detect_enable_bit = 2;

  localparam logic [7:0] mode_control_reset = 8'h00;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] config_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [7:0] counter_max = 8'hFF;
  localparam logic [1:0] div3_last = 2'h2;

  typedef enum logic [1:0] {
    mode_auto_reload = 2'b00,
    mode_capture = 2'b01,
    mode_capture_clear = 2'b10,
    mode_external_load = 2'b11
  } timer_mode_type;

  typedef enum logic [1:0] {
    clock_internal = 2'b00,
    clock_internal_div3 = 2'b01,
    clock_input_pin = 2'b10,
    clock_reserved = 2'b11
  } clock_sel_type;

  typedef struct packed {
    logic count_enable;
    logic pulse_output_enable;
    logic edge_irq_enable;
    logic match_irq_enable;
    logic rollover_irq_enable;
    timer_mode_type mode;
  } mode_control_type;

  typedef struct packed {
    logic [2:0] prescale_sel;
    logic reserved;
    logic edge_polarity;
    logic edge_detect_enable;
    clock_sel_type clock_sel;
  } clock_edge_config_type;

  typedef struct packed {
    logic edge_flag;
    logic match_flag;
    logic rollover_flag;
  } event_flags_type;

  typedef struct packed {
    logic edge_irq;
    logic match_irq;
    logic rollover_irq;
  } irq_type;
endpackage

/* File: verification/auto_reload_timer_regs_properties.sv */
// checker: port-level properties of the auto-reload timer
module auto_reload_timer_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic timer_input_pin,
  input wire logic pulse_output_pin,
  input wire ar_timer_pkg::irq_type irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_d;
  logic chg;
  logic wm;
  logic wf;
  assign chg = timer_input_pin != pin_d;
  assign wm = psel && penable && pwrite && pstrb[0] && paddr == 12'h354;
  assign wf = psel && penable && pwrite && pstrb[0] && paddr == 12'h358;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_d <= 1'b0;
    else pin_d <= timer_input_pin;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !pulse_output_pin && irq_request == 3'h0)
    else $error("outputs active after reset");
  AST_OE_OFF: assert property (wm && !pwdata[5] |=> !pulse_output_pin)
    else $error("pulse pin driven while disabled");
  AST_EDGE_MASK: assert property (wm && !pwdata[4] |=> !irq_request.edge_irq)
    else $error("edge request not masked");
  AST_MATCH_MASK: assert property (wm && !pwdata[3] |=> !irq_request.match_irq)
    else $error("match request not masked");
  AST_ROLL_MASK: assert property (wm && !pwdata[2] |=> !irq_request.rollover_irq)
    else $error("rollover request not masked");
  AST_LOAD_READ_ZERO: assert property (psel && penable && !pwrite && paddr == 12'h354 |-> !prdata[7])
    else $error("load trigger read back as one");
  AST_EDGE_CAUSE: assert property ($rose(irq_request.edge_irq) |-> $past(chg) || $past(chg, 2) || $past(chg, 3) || $past(wm))
    else $error("edge request without pin edge");
  AST_FLAG_CLEAR: assert property (wf && !pwdata[2] && !chg && !$past(chg) |=> !irq_request.edge_irq)
    else $error("edge flag not cleared by zero write");
  cover property ($rose(pulse_output_pin));
  cover property ($rose(irq_request.edge_irq));
  cover property ($rose(irq_request.rollover_irq));
endmodule // auto_reload_timer_regs_properties

bind auto_reload_timer_regs auto_reload_timer_regs_properties auto_reload_timer_regs_properties_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .timer_input_pin, .pulse_output_pin, .irq_request);

/* File: verification/pulse_source.sv */
// partner: external pulse source driving the timer input pin
module pulse_source (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // changes only just after an edge; hold sets how soon the next edge may follow
  task automatic flip(input int hold);
    @(posedge clk);
    pin <= ~pin;
    repeat (hold) @(posedge clk);
  endtask
endmodule // pulse_source

/* File: verification/test_auto_reload_timer_regs.sv */
// testbench: apb register traffic, counting, capture and pin loads
module test_auto_reload_timer_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pstrb;
  logic [7:0] v;
  ar_timer_pkg::irq_type irq;
  logic [31:0] exp_q[$];
  logic err_q[$];
  int bad_count = 0;
  int n_tests = 0;
  auto_reload_timer_regs auto_reload_timer_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .timer_input_pin(pin), .pulse_output_pin(pulse), .irq_request(irq));
  pulse_source pulse_source_i (.clk(pclk), .pin);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic fail(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic end_sim();
    $display("%0d comparisons, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s0, input logic e);
    int n;
    err_q.push_back(e);
    @(posedge pclk);
    rnd = lfsr(rnd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rnd[31:8], d};
    pstrb <= {rnd[3:1], s0};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail("no ready");
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    apb(1'b1, {2'h0, ix, 2'h0}, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb(1'b0, {2'h0, ix, 2'h0}, 8'h00, 1'b1, 1'b0);
  endtask
  // refused or strobe-less access: refused reads return zero, refused or strobe-less writes must not land
  task automatic bad(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s0, input logic e);
    if (!w) exp_q.push_back(32'h0000_0000);
    apb(w, a, d, s0, e);
  endtask
  // answer taken at the edge where pready is sampled high, values from before that edge
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1) begin
      check_err();
      if (!pwrite) check_rd();
    end
  end
  task automatic check_err();
    logic e;
    if (err_q.size() == 0) begin
      fail("access with no note");
      return;
    end
    e = err_q.pop_front();
    n_tests++;
    if (pslverr !== e) fail($sformatf("error flag %b expected %b", pslverr, e));
  endtask
  task automatic check_rd();
    logic [31:0] e;
    if (exp_q.size() == 0) begin
      fail("read with no note");
      return;
    end
    e = exp_q.pop_front();
    n_tests++;
    if (prdata !== e) fail($sformatf("read %h expected %h", prdata, e));
  endtask
  task automatic check_out(input logic [3:0] e);
    @(negedge pclk);
    n_tests++;
    if ({pulse, irq} !== e) fail($sformatf("pins %b expected %b", {pulse, irq}, e));
  endtask
  task automatic wait_out(input int k, input logic lvl);
    int n;
    logic [3:0] o;
    for (n = 0; n < 300; n++) begin
      @(negedge pclk);
      o = {pulse, irq};
      if (o[k] === lvl) break;
    end
    if (n == 300) begin
      fail("output never changed");
      end_sim();
    end
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h1;
    rnd = 32'h39db_fba7;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'hd5, 8'h00);
    bad(1'b0, 12'h360, 8'h00, 1'b1, 1'b1);
    v = rnd[7:0];
    wr(8'hda, v);
    rd(8'hda, v);
    bad(1'b0, 12'h355, 8'h00, 1'b1, 1'b1);
    bad(1'b0, 12'hF54, 8'h00, 1'b1, 1'b1);
    bad(1'b1, 12'h36A, ~v, 1'b1, 1'b1);
    bad(1'b1, 12'h368, ~v, 1'b0, 1'b0);
    rd(8'hda, v);
    wr(8'hd7, 8'hf3);
    rd(8'hd7, 8'hf3);
    wr(8'hdb, 8'h20);
    wr(8'hd5, 8'h40);
    repeat (20) @(posedge pclk);
    rd(8'hdb, 8'h20);
    $display("test registers done");
    wr(8'hd7, 8'h00);
    wr(8'hd9, 8'h10);
    wr(8'hda, 8'h20);
    wr(8'hdb, 8'hf0);
    wr(8'hd5, 8'h64);
    wait_out(0, 1'b1);
    check_out(4'b1001);
    wait_out(3, 1'b0);
    wr(8'hd5, 8'h00);
    check_out(4'b0000);
    rd(8'hd6, 8'h03);
    wr(8'hd6, 8'h06);
    rd(8'hd6, 8'h02);
    wr(8'hd6, 8'h00);
    wr(8'hdb, 8'h33);
    repeat (10) @(posedge pclk);
    rd(8'hdb, 8'h33);
    wr(8'hd5, 8'h80);
    rd(8'hdb, 8'h10);
    rd(8'hd5, 8'h00);
    $display("test counting done");
    v = rnd[7:0];
    wr(8'hd7, 8'h04);
    wr(8'hdb, v);
    wr(8'hd5, 8'h11);
    pulse_source_i.flip(3);
    check_out(4'b0100);
    rd(8'hd9, v);
    wr(8'hd6, 8'h00);
    check_out(4'b0000);
    wr(8'hd7, 8'h0c);
    pulse_source_i.flip(3);
    rd(8'hd6, 8'h04);
    wr(8'hd6, 8'h00);
    pulse_source_i.flip(1);
    rd(8'hd6, 8'h00);
    $display("test capture done");
    wr(8'hd5, 8'h02);
    wr(8'hdb, 8'h40);
    pulse_source_i.flip(3);
    rd(8'hd9, 8'h40);
    rd(8'hdb, 8'h00);
    wr(8'hd9, 8'h77);
    wr(8'hd5, 8'h03);
    pulse_source_i.flip(2);
    rd(8'hdb, 8'h00);
    pulse_source_i.flip(2);
    rd(8'hdb, 8'h77);
    $display("test pin load done");
    repeat (3) @(posedge pclk);
    end_sim();
  end
endmodule // test_auto_reload_timer_regs
